// *** clb_dev.sv ***
`timescale 1ns/10ps
// Overview of operation
// - AD lines: address T1, data after, float on hold
// - Upper address held valid T1 through T4
// - T1 top bits address, low for I/O
// - Later states: status, top zero, IE flag
// - Two status bits encode segment in use
// - Read strobe low T2,T3,Tw; high in grant
// - Ready comes pre-synchronised from addressed device
// - Maskable request sampled at instruction end, gated
// - Wait-for-test proceeds while test input low
// - Rising NMI edge causes unmaskable interrupt
// - Reset held four clocks, terminates activity
// - Cycle status active early, passive from T3
// - Cycle status codes mark each cycle start
// - Two request/grant pins, channel zero first
// - Requester sends one-clock low request pulse
// - Grant pulse in T4 or an idle clock, then grant state
// - Third pulse ends tenure, one reclaim clock, then idle
// - Release in T4 only when conditions allow
// - Idle bus released on next clock
// - Lock output follows locked instruction, high granted
// - Queue tracking outputs follow queue operation
// - Mode input low selects maximum mode
module clb_dev (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  clb_if.dev               b,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [2:0]  req_kind,
  input  wire logic [19:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  input  wire logic [1:0]  req_seg,
  input  wire logic        req_word_lo,
  input  wire logic        req_inta_first,
  input  wire logic        lock_active,
  input  wire logic        int_enable,
  input  wire logic        instr_last,
  input  wire logic        wait_test,
  input  wire logic [1:0]  queue_op,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             core_reset,
  output logic             irq_take,
  output logic             nmi_take,
  output logic             test_go,
  output logic             max_mode,
  output logic             bus_granted
);
  import clb_pkg::*;

  typedef struct packed {
    clb_tstate_t st;
    logic [6:0]  s1;
    logic [6:0]  s2;
    logic [2:0]  edg;
    logic [2:0]  kind;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic [1:0]  seg;
    logic        wlo;
    logic        ia1;
    logic        pend;
    logic        pch;
    logic        elig;
    logic        gnt;
    logic        gch;
    logic [1:0]  ign;
    logic [7:0]  ad_o;
    logic        ad_oe_n;
    logic [7:0]  up;
    logic        up_oe_n;
    logic [3:0]  top;
    logic        ctl_oe_n;
    logic        rd_n;
    logic [2:0]  cs;
    logic        lock_n;
    logic [1:0]  qt;
    logic        ie;
    logic [7:0]  rdata;
    logic        rsp;
    logic        nmi_p;
    logic        nmi_t;
    logic        irq_t;
    logic        tgo;
    logic        maxm;
  } clb_dev_st_t;

  clb_dev_st_t q;
  clb_dev_st_t d;
  logic        fall0;
  logic        fall1;
  logic        nmi_rise;
  logic        take;
  logic        active;
  logic        data_ph;
  logic        granted;

  // ----------------------------------------------------------------
  // Cycle acceptance
  // ----------------------------------------------------------------
  assign req_ready = ce & ~q.s2[SY_RST] & ~q.pend & ~q.gnt & ((q.st == TS_IDLE) | (q.st == TS_T4));
  assign take      = req_ready & req_valid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.s1    = {b.bus_mode_select, b.req_grant_low_prio, b.req_grant_high_prio, b.test_n, b.nmi,
               b.maskable_irq, b.cpu_reset};
    d.s2    = q.s1;
    d.edg   = {q.s2[SY_RG1], q.s2[SY_RG0], q.s2[SY_NMI]};
    // Own grant pulse comes back through the synchroniser; mask it out
    fall0   = q.edg[1] & ~q.s2[SY_RG0] & (q.ign == 2'h0);
    fall1   = q.edg[2] & ~q.s2[SY_RG1] & (q.ign == 2'h0);
    nmi_rise = ~q.edg[0] & q.s2[SY_NMI];
    d.ie    = int_enable;
    d.qt    = queue_op;
    d.maxm  = ~q.s2[SY_MODE];
    d.tgo   = wait_test & ~q.s2[SY_TEST];
    d.nmi_t = instr_last & q.nmi_p;
    d.irq_t = instr_last & ~q.nmi_p & q.s2[SY_IRQ] & q.ie;
    d.nmi_p = (q.nmi_p & ~instr_last) | nmi_rise;
    d.rsp   = 1'b0;
    d.ign   = (q.ign != 2'h0) ? q.ign - 2'h1 : 2'h0;
    if (!q.pend && q.st != TS_GRANT && q.maxm && (fall0 || fall1)) begin
      d.pend = 1'b1;
      d.pch  = ~fall0;
    end
    if ((q.st == TS_T1 || q.st == TS_T2) && d.pend) d.elig = 1'b1;
    if (q.gnt) begin
      d.gnt = 1'b0;
      d.st  = TS_GRANT;
    end else begin
      case (q.st)
        TS_IDLE: begin
          if (q.pend) begin
            d.gnt  = 1'b1;
            d.gch  = q.pch;
            d.pend = 1'b0;
            d.ign  = GRANT_MASK_CLKS;
          end else if (take) begin
            d.st = TS_T1;
          end
        end
        TS_T1: d.st = TS_T2;
        TS_T2: d.st = TS_T3;
        TS_T3, TS_TW: begin
          if (b.ready) begin
            d.st   = TS_T4;
            d.rsp  = 1'b1;
            d.elig = 1'b0;
            if (!clb_is_write(q.kind)) d.rdata = b.ad_bus;
            if (q.pend && q.elig && !lock_active && !q.wlo && !q.ia1) begin
              d.gnt  = 1'b1;
              d.gch  = q.pch;
              d.pend = 1'b0;
              d.ign  = GRANT_MASK_CLKS;
            end
          end else begin
            d.st = TS_TW;
          end
        end
        TS_T4: d.st = take ? TS_T1 : TS_IDLE;
        TS_GRANT: if (q.gch ? fall1 : fall0) d.st = TS_RECLAIM;
        TS_RECLAIM: d.st = TS_IDLE;
        default: d.st = TS_IDLE;
      endcase
    end
    if (take) begin
      d.kind  = req_kind;
      d.addr  = req_addr;
      d.wdata = req_wdata;
      d.seg   = req_seg;
      d.wlo   = req_word_lo;
      d.ia1   = req_inta_first;
    end
    // Synchronised reset returns the cycle to idle and clears grant and interrupt state at once
    if (q.s2[SY_RST]) begin
      d.st    = TS_IDLE;
      d.pend  = 1'b0;
      d.elig  = 1'b0;
      d.gnt   = 1'b0;
      d.nmi_p = 1'b0;
      d.nmi_t = 1'b0;
      d.irq_t = 1'b0;
    end

    // Pins follow the next state, so they change on the same edge
    active    = (d.st == TS_T1) || (d.st == TS_T2) || (d.st == TS_T3) || (d.st == TS_TW) || (d.st == TS_T4);
    data_ph   = (d.st == TS_T2) || (d.st == TS_T3) || (d.st == TS_TW) || (d.st == TS_T4);
    granted   = (d.st == TS_GRANT);
    d.ad_oe_n = ~(((d.st == TS_T1) && d.kind != CS_INTA) || (data_ph && clb_is_write(d.kind)));
    if (d.st == TS_T1) begin
      d.ad_o = d.addr[7:0];
      d.up   = d.addr[15:8];
      d.top  = (d.kind == CS_IORD || d.kind == CS_IOWR) ? 4'h0 : d.addr[19:16];
    end else if (data_ph) begin
      if (clb_is_write(d.kind)) d.ad_o = d.wdata;
      d.top = {1'b0, int_enable, d.seg};
    end
    d.up_oe_n  = granted || (active && d.kind == CS_INTA);
    d.ctl_oe_n = granted;
    d.rd_n     = ~(clb_is_read(d.kind) && data_ph && d.st != TS_T4);
    d.cs       = (q.maxm && (d.st == TS_T1 || d.st == TS_T2)) ? d.kind : CS_PASS;
    d.lock_n   = ~(lock_active && !granted);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.s1       <= SYNC_RST;
      q.s2       <= SYNC_RST;
      q.edg      <= EDGE_RST;
      q.ad_oe_n  <= 1'b1;
      q.up_oe_n  <= 1'b1;
      q.ctl_oe_n <= 1'b1;
      q.rd_n     <= 1'b1;
      q.cs       <= CS_PASS;
      q.lock_n   <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Pins and user side
  // ----------------------------------------------------------------
  assign b.ad_dev_o         = q.ad_o;
  assign b.ad_dev_oe_n      = q.ad_oe_n;
  assign b.upper_addr_lines = q.up;
  assign b.upper_oe_n       = q.up_oe_n;
  assign b.top_addr_status  = q.top;
  assign b.ctl_oe_n         = q.ctl_oe_n;
  assign b.rd_n             = q.rd_n;
  assign b.cycle_status     = q.cs;
  assign b.lock_n           = q.lock_n;
  assign b.queue_track      = q.qt;
  assign b.rg_hi_dev_o      = 1'b0;
  assign b.rg_lo_dev_o      = 1'b0;
  assign b.rg_hi_dev_oe_n   = ~(q.gnt & ~q.gch);
  assign b.rg_lo_dev_oe_n   = ~(q.gnt & q.gch);
  assign rsp_valid          = q.rsp;
  assign rsp_data           = q.rdata;
  assign core_reset         = q.s2[SY_RST];
  assign irq_take           = q.irq_t;
  assign nmi_take           = q.nmi_t;
  assign test_go            = q.tgo;
  assign max_mode           = q.maxm;
  assign bus_granted        = (q.st == TS_GRANT);

endmodule : clb_dev

// *** clb_host.sv ***
`timescale 1ns/10ps
module clb_host #(
  parameter bit USE_LOW_PRIO = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  clb_if.host              b,
  input  wire logic        reset_req,
  input  wire logic        irq_level,
  input  wire logic        nmi_level,
  input  wire logic        test_level_n,
  input  wire logic        mode_sel,
  output logic             mst_valid,
  output logic [2:0]       mst_kind,
  output logic [19:0]      mst_addr,
  output logic [7:0]       mst_wdata,
  input  wire logic        slv_valid,
  input  wire logic [7:0]  slv_rdata,
  input  wire logic        bus_want,
  output logic             bus_own,
  output logic             lock_seen,
  output logic [1:0]       queue_seen
);
  import clb_pkg::*;

  typedef struct packed {
    clb_hstate_t st;
    logic [2:0]  rcnt;
    logic        rst_o;
    logic [3:0]  pins;
    logic [2:0]  cs_prev;
    logic        cap;
    logic [2:0]  kind;
    logic [19:0] addr;
    logic        rdy;
    logic [7:0]  rdata;
    logic        mv;
    logic [7:0]  mwd;
  } clb_host_st_t;

  clb_host_st_t q;
  clb_host_st_t d;
  logic         rg_in;
  logic         pull;

  assign rg_in = USE_LOW_PRIO ? b.req_grant_low_prio : b.req_grant_high_prio;
  assign pull  = (q.st == HS_ASK) || (q.st == HS_DONE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.pins    = {mode_sel, test_level_n, nmi_level, irq_level};
    d.cs_prev = b.cycle_status;
    d.mv      = 1'b0;
    if (reset_req) begin
      d.rcnt = 3'(RESET_HOLD_CLKS);
    end else if (q.rcnt != 3'h0) begin
      d.rcnt = q.rcnt - 3'h1;
    end
    d.rst_o = (d.rcnt != 3'h0);
    if (q.cap) begin
      d.mv  = 1'b1;
      d.mwd = b.ad_bus;
      d.cap = 1'b0;
    end
    if (b.cycle_status != CS_PASS && q.cs_prev == CS_PASS) begin
      d.cap  = 1'b1;
      d.kind = b.cycle_status;
      d.addr = {b.top_addr_status, b.upper_addr_lines, b.ad_bus};
      d.rdy  = 1'b0;
    end else if (slv_valid && !q.rdy) begin
      d.rdy   = 1'b1;
      d.rdata = slv_rdata;
    end
    case (q.st)
      HS_IDLE: if (bus_want) d.st = HS_ASK;
      HS_ASK:  d.st = HS_WAIT;
      HS_WAIT: if (!rg_in) d.st = HS_OWN;
      HS_OWN:  if (!bus_want) d.st = HS_DONE;
      HS_DONE: d.st = HS_GAP;
      HS_GAP:  d.st = HS_IDLE;
      default: d.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.rcnt    <= 3'(RESET_HOLD_CLKS);
      q.rst_o   <= 1'b1;
      q.pins    <= 4'h4;
      q.cs_prev <= CS_PASS;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Pins and user side
  // ----------------------------------------------------------------
  assign b.cpu_reset       = q.rst_o;
  assign b.maskable_irq    = q.pins[0];
  assign b.nmi             = q.pins[1];
  assign b.test_n          = q.pins[2];
  assign b.bus_mode_select = q.pins[3];
  assign b.ready           = q.rdy;
  assign b.ad_host_o       = q.rdata;
  // Drive only while the strobe is low, so the next address phase never collides
  assign b.ad_host_oe_n    = ~(q.rdy & ~b.rd_n);
  assign b.rg_hi_host_o    = 1'b0;
  assign b.rg_lo_host_o    = 1'b0;
  assign b.rg_hi_host_oe_n = ~(pull & ~USE_LOW_PRIO);
  assign b.rg_lo_host_oe_n = ~(pull & USE_LOW_PRIO);
  assign mst_valid         = q.mv;
  assign mst_kind          = q.kind;
  assign mst_addr          = q.addr;
  assign mst_wdata         = q.mwd;
  assign bus_own           = (q.st == HS_OWN);
  assign lock_seen         = ~b.lock_n;
  assign queue_seen        = b.queue_track;

endmodule : clb_host

// *** clb_if.sv ***
`timescale 1ns/10ps
interface clb_if;
  logic [7:0] ad_dev_o;
  logic       ad_dev_oe_n;
  logic [7:0] ad_host_o;
  logic       ad_host_oe_n;
  logic [7:0] ad_bus;
  logic [7:0] upper_addr_lines;
  logic       upper_oe_n;
  logic [3:0] top_addr_status;
  logic       ctl_oe_n;
  logic       rd_n;
  logic [2:0] cycle_status;
  logic       lock_n;
  logic [1:0] queue_track;
  logic       ready;
  logic       maskable_irq;
  logic       nmi;
  logic       test_n;
  logic       cpu_reset;
  logic       bus_mode_select;
  logic       rg_hi_dev_o;
  logic       rg_hi_dev_oe_n;
  logic       rg_lo_dev_o;
  logic       rg_lo_dev_oe_n;
  logic       rg_hi_host_o;
  logic       rg_hi_host_oe_n;
  logic       rg_lo_host_o;
  logic       rg_lo_host_oe_n;
  logic       req_grant_high_prio;
  logic       req_grant_low_prio;

  // Undriven bus keeps the device's last level
  assign ad_bus = !ad_dev_oe_n ? ad_dev_o : (!ad_host_oe_n ? ad_host_o : ad_dev_o);
  // Wired-low lines, held high when nobody pulls
  assign req_grant_high_prio = (rg_hi_dev_oe_n | rg_hi_dev_o) & (rg_hi_host_oe_n | rg_hi_host_o);
  assign req_grant_low_prio  = (rg_lo_dev_oe_n | rg_lo_dev_o) & (rg_lo_host_oe_n | rg_lo_host_o);

  modport dev (
    output ad_dev_o, ad_dev_oe_n, upper_addr_lines, upper_oe_n, top_addr_status, ctl_oe_n, rd_n,
    output cycle_status, lock_n, queue_track, rg_hi_dev_o, rg_hi_dev_oe_n, rg_lo_dev_o, rg_lo_dev_oe_n,
    input  ad_bus, ready, maskable_irq, nmi, test_n, cpu_reset, bus_mode_select,
    input  req_grant_high_prio, req_grant_low_prio
  );
  modport host (
    output ad_host_o, ad_host_oe_n, ready, maskable_irq, nmi, test_n, cpu_reset, bus_mode_select,
    output rg_hi_host_o, rg_hi_host_oe_n, rg_lo_host_o, rg_lo_host_oe_n,
    input  ad_bus, upper_addr_lines, upper_oe_n, top_addr_status, ctl_oe_n, rd_n, cycle_status,
    input  lock_n, queue_track, req_grant_high_prio, req_grant_low_prio
  );
endinterface : clb_if

// *** clb_pkg.sv ***
package clb_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS   = 50;
  localparam int         RESET_HOLD_CLKS = 4;
  localparam logic [1:0] GRANT_MASK_CLKS = 2'h3;

  // ----------------------------------------------------------------
  // Cycle status, segment and queue codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_INTA = 3'h0;
  localparam logic [2:0] CS_IORD = 3'h1;
  localparam logic [2:0] CS_IOWR = 3'h2;
  localparam logic [2:0] CS_HALT = 3'h3;
  localparam logic [2:0] CS_CODE = 3'h4;
  localparam logic [2:0] CS_MRD  = 3'h5;
  localparam logic [2:0] CS_MWR  = 3'h6;
  localparam logic [2:0] CS_PASS = 3'h7;
  localparam logic [1:0] SEG_ALT   = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  localparam logic [1:0] SEG_CODE  = 2'h2;
  localparam logic [1:0] SEG_DATA  = 2'h3;
  localparam logic [1:0] QT_NOP   = 2'h0;
  localparam logic [1:0] QT_FIRST = 2'h1;
  localparam logic [1:0] QT_EMPTY = 2'h2;
  localparam logic [1:0] QT_NEXT  = 2'h3;

  // ----------------------------------------------------------------
  // Synchroniser layout and reset values
  // ----------------------------------------------------------------
  localparam int         SY_RST  = 0;
  localparam int         SY_IRQ  = 1;
  localparam int         SY_NMI  = 2;
  localparam int         SY_TEST = 3;
  localparam int         SY_RG0  = 4;
  localparam int         SY_RG1  = 5;
  localparam int         SY_MODE = 6;
  // Reset pin idles high, so the core starts out held in reset
  localparam logic [6:0] SYNC_RST = 7'h39;
  localparam logic [2:0] EDGE_RST = 3'h6;

  typedef enum logic [2:0] {TS_IDLE, TS_T1, TS_T2, TS_T3, TS_TW, TS_T4, TS_GRANT, TS_RECLAIM} clb_tstate_t;
  typedef enum logic [2:0] {HS_IDLE, HS_ASK, HS_WAIT, HS_OWN, HS_DONE, HS_GAP} clb_hstate_t;

  function automatic logic clb_is_read(input logic [2:0] k);
    return (k == CS_IORD) || (k == CS_MRD) || (k == CS_CODE);
  endfunction : clb_is_read

  function automatic logic clb_is_write(input logic [2:0] k);
    return (k == CS_IOWR) || (k == CS_MWR);
  endfunction : clb_is_write

endpackage : clb_pkg

// *** clb_sva.sv ***
`timescale 1ns/10ps
module clb_sva (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       ad_dev_oe_n,
  input wire logic [7:0] upper_addr_lines,
  input wire logic       upper_oe_n,
  input wire logic [3:0] top_addr_status,
  input wire logic       ctl_oe_n,
  input wire logic       rd_n,
  input wire logic [2:0] cycle_status,
  input wire logic       lock_n,
  input wire logic       rg_hi_dev_oe_n
);
  import clb_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Cycle start: status leaves passive
  // ----------------------------------------------------------------
  logic [2:0] st_q;
  logic       start;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= CS_PASS;
    end else begin
      st_q <= cycle_status;
    end
  end
  assign start = (st_q == CS_PASS) && (cycle_status != CS_PASS);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_io_top_low: assert property (start && (cycle_status == CS_IORD || cycle_status == CS_IOWR) |->
    top_addr_status == 4'h0) else $error("io cycle shows address on top lines");
  a_status_span: assert property (start |=> cycle_status == $past(cycle_status) ##1 cycle_status == CS_PASS)
    else $error("cycle status span wrong");
  a_addr_hold: assert property (start && cycle_status != CS_INTA |-> (!upper_oe_n && !ad_dev_oe_n)
    ##1 (!upper_oe_n && $stable(upper_addr_lines)) [*3]) else $error("upper address not held");
  a_read_strobe: assert property (start && (cycle_status == CS_MRD || cycle_status == CS_IORD
    || cycle_status == CS_CODE) |=> !rd_n) else $error("read strobe missing in T2");
  a_rd_floated: assert property (!rd_n |-> ad_dev_oe_n) else $error("read strobe while driving bus");
  a_status_top: assert property (cycle_status != CS_PASS && st_q == cycle_status |-> !top_addr_status[3])
    else $error("top status bit high");
  a_grant_rd: assert property (ctl_oe_n |-> rd_n) else $error("read strobe low in grant");
  a_grant_lock: assert property (ctl_oe_n |-> lock_n && cycle_status == CS_PASS)
    else $error("lock or status active in grant");
  a_grant_pulse: assert property ($fell(rg_hi_dev_oe_n) |=> rg_hi_dev_oe_n ##[0:1] ctl_oe_n)
    else $error("grant pulse width or float wrong");
endmodule : clb_sva

// *** testbench.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
  import clb_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, req_valid = 1'b0, req_word_lo = 1'b0;
  logic        req_inta_first = 1'b0, lock_active = 1'b0, int_enable = 1'b0, instr_last = 1'b0;
  logic        wait_test = 1'b0, reset_req = 1'b0, irq_level = 1'b0, nmi_level = 1'b0, test_level_n = 1'b1;
  logic        mode_sel = 1'b0, slv_valid = 1'b0, bus_want = 1'b0;
  logic [2:0]  req_kind = 3'h7, mk, mst_kind;
  logic [19:0] req_addr = 20'h0, ma, mst_addr;
  logic [7:0]  req_wdata = 8'h0, slv_rdata = 8'h0, mw, mst_wdata, rsp_data;
  logic [1:0]  req_seg = 2'h0, queue_op = 2'h0, queue_seen;
  logic [3:0]  tops;
  logic        req_ready, rsp_valid, core_reset, irq_take, nmi_take, test_go, max_mode, bus_granted;
  logic        mst_valid, bus_own, lock_seen;
  int          fail_count = 0, checks = 0, lat = 0, wcnt = 0, n;
  logic [2:0]  kinds [5] = '{CS_MRD, CS_IORD, CS_CODE, CS_MWR, CS_IOWR};

  always #25 clk_sys = ~clk_sys;

  clb_if bus ();
  clb_dev u_clb_dev (.clk_sys, .rst_n, .ce, .b(bus), .req_valid, .req_ready, .req_kind, .req_addr, .req_wdata,
    .req_seg, .req_word_lo, .req_inta_first, .lock_active, .int_enable, .instr_last, .wait_test, .queue_op,
    .rsp_valid, .rsp_data, .core_reset, .irq_take, .nmi_take, .test_go, .max_mode, .bus_granted);
  clb_host u_clb_host (.clk_sys, .rst_n, .ce, .b(bus), .reset_req, .irq_level, .nmi_level, .test_level_n,
    .mode_sel, .mst_valid, .mst_kind, .mst_addr, .mst_wdata, .slv_valid, .slv_rdata, .bus_want, .bus_own,
    .lock_seen, .queue_seen);
  clb_sva u_chk (.clk_sys, .rst_n, .ad_dev_oe_n(bus.ad_dev_oe_n), .upper_addr_lines(bus.upper_addr_lines),
    .upper_oe_n(bus.upper_oe_n), .top_addr_status(bus.top_addr_status), .ctl_oe_n(bus.ctl_oe_n),
    .rd_n(bus.rd_n), .cycle_status(bus.cycle_status), .lock_n(bus.lock_n), .rg_hi_dev_oe_n(bus.rg_hi_dev_oe_n));

  // ----------------------------------------------------------------
  // Slave side: captures the cycle, answers after lat extra clocks
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (mst_valid) begin
      mk <= mst_kind;
      ma <= mst_addr;
      mw <= mst_wdata;
      tops <= bus.top_addr_status;
      slv_rdata <= #2 mst_addr[7:0] ^ 8'h5a;
    end
    wcnt <= mst_valid ? lat + 1 : (wcnt > 0 ? wcnt - 1 : 0);
    slv_valid <= #2 (wcnt == 1);
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic bus_op(input logic [2:0] k, input logic [19:0] a, input logic [7:0] d, input logic [1:0] s,
                        input logic ie);
    int          w;
    logic [19:0] ea;
    ea = (k == CS_IORD || k == CS_IOWR) ? {4'h0, a[15:0]} : a;
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_seg = s;
    int_enable = ie;
    req_valid = 1'b1;
    w = 0;
    while (req_ready !== 1'b1 && w < 40) begin tick(1); w++; end
    `CHK(req_ready, 1'b1)
    tick(1);
    req_valid = 1'b0;
    w = 0;
    while (rsp_valid !== 1'b1 && w < 40) begin tick(1); w++; end
    `CHK(rsp_valid, 1'b1)
    if (k == CS_MWR || k == CS_IOWR) `CHK(mw, d)
    else `CHK(rsp_data, a[7:0] ^ 8'h5a)
    `CHK(mk, k)
    `CHK(ma, ea)
    `CHK(tops, {1'b0, ie, s})
  endtask : bus_op

  task automatic pulse_last(input logic ei, input logic en);
    instr_last = 1'b1;
    tick(1);
    `CHK(irq_take, ei)
    `CHK(nmi_take, en)
    instr_last = 1'b0;
    // One quiet clock so back-to-back calls never retoggle in one step
    tick(1);
  endtask : pulse_last

  initial begin
    tick(16);
    rst_n = 1'b1;
    n = 0;
    while (core_reset !== 1'b0 && n < 40) begin tick(1); n++; end
    `CHK(core_reset, 1'b0)
    `CHK(max_mode, 1'b1)
    for (int i = 0; i < 10; i++) begin
      lat = i % 3;
      bus_op(kinds[i % 5], 20'h9a3c0 + 20'(i) * 20'h11111, 8'h30 + 8'(i), i[1:0], i[0]);
    end
    irq_level = 1'b1;
    int_enable = 1'b1;
    tick(6);
    pulse_last(1'b1, 1'b0);
    int_enable = 1'b0;
    // Enable flag is registered, so give it one clock to land
    tick(1);
    pulse_last(1'b0, 1'b0);
    irq_level = 1'b0;
    nmi_level = 1'b1;
    tick(6);
    pulse_last(1'b0, 1'b1);
    pulse_last(1'b0, 1'b0);
    nmi_level = 1'b0;
    wait_test = 1'b1;
    test_level_n = 1'b0;
    tick(5);
    `CHK(test_go, 1'b1)
    test_level_n = 1'b1;
    tick(5);
    `CHK(test_go, 1'b0)
    for (int q = 0; q < 4; q++) begin
      queue_op = 2'(q);
      tick(1);
      `CHK(queue_seen, 2'(q))
    end
    // Clock enable low must freeze the tracking outputs
    ce = 1'b0;
    queue_op = 2'h0;
    tick(2);
    `CHK(queue_seen, 2'h3)
    ce = 1'b1;
    lock_active = 1'b1;
    tick(2);
    `CHK(bus.lock_n, 1'b0)
    lock_active = 1'b0;
    tick(2);
    `CHK(bus.lock_n, 1'b1)
    bus_want = 1'b1;
    n = 0;
    while (bus_own !== 1'b1 && n < 30) begin tick(1); n++; end
    `CHK(bus_granted, 1'b1)
    `CHK(bus.ctl_oe_n, 1'b1)
    `CHK(req_ready, 1'b0)
    bus_want = 1'b0;
    n = 0;
    while (bus_granted !== 1'b0 && n < 30) begin tick(1); n++; end
    `CHK(bus_granted, 1'b0)
    bus_op(CS_MRD, 20'h12345, 8'h00, SEG_DATA, 1'b1);
    reset_req = 1'b1;
    tick(1);
    reset_req = 1'b0;
    n = 0;
    while (core_reset !== 1'b1 && n < 10) begin tick(1); n++; end
    n = 0;
    while (core_reset === 1'b1 && n < 20) begin tick(1); n++; end
    `CHK(n >= RESET_HOLD_CLKS, 1'b1)
    bus_op(CS_MWR, 20'h4567a, 8'ha5, SEG_STACK, 1'b0);
    mode_sel = 1'b1;
    tick(4);
    `CHK(max_mode, 1'b0)
    close_out();
  end

  // Tests take under 1000 clocks; allow three times that
  initial begin
    #(50 * 3000);
    fail_count++;
    close_out();
  end
endmodule : testbench
